/* File: rtl/nand_cycle_engine.sv */
// Purpose: drives one command, address or read cycle on the flash pins
// Assumes: caller waits for done before the next request
// Notes: read cycles keep the strobe low half a period, high half
`timescale 1ns/10ps
module nand_cycle_engine (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // request
  input wire logic req_valid,
  input wire nand_host_pkg::cyc_req_t req,
  output logic done,
  output logic [7:0] rd_byte,
  // pins
  input wire logic [7:0] io_in,
  output nand_host_pkg::pins_t pins
);
  // ==========================================================
  // phase machine
  typedef enum logic [3:0] {
    P_IDLE = 4'b0001,
    P_LOW = 4'b0010,
    P_HIGH = 4'b0100,
    P_GAP = 4'b1000
  } phase_t;
  phase_t phase_reg, phase_next;
  logic [7:0] cnt_reg, cnt_next;  // phase timer
  nand_host_pkg::cyc_req_t cur_reg, cur_next;  // request in flight
  nand_host_pkg::pins_t pins_reg, pins_next;
  logic done_reg, done_next;
  logic [7:0] byte_reg, byte_next;
  logic last_rd_reg, last_rd_next;  // turnaround needs know prior kind

  assign pins = pins_reg;
  assign done = done_reg;
  assign rd_byte = byte_reg;

  // next-state: a write cycle pulses write_n, a read cycle pulses the strobe
  always_comb begin
    phase_next = phase_reg;
    cnt_next = cnt_reg;
    cur_next = cur_reg;
    pins_next = pins_reg;
    done_next = 1'b0;
    byte_next = byte_reg;
    last_rd_next = last_rd_reg;
    case (phase_reg)
      P_IDLE: begin
        if (req_valid) begin
          cur_next = req;
          // turnaround between a write and a read in either order
          if (req.kind == nand_host_pkg::CYC_READ && !last_rd_reg) begin
            cnt_next = 8'(nand_host_pkg::WRITE_TO_STROBE_CYC);
          end else if (req.kind != nand_host_pkg::CYC_READ && last_rd_reg) begin
            cnt_next = 8'(nand_host_pkg::STROBE_TO_WRITE_CYC);
          end else begin
            cnt_next = 8'h00;
          end
          phase_next = P_GAP;
        end
      end
      P_GAP: begin
        if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          pins_next.cle = (cur_reg.kind == nand_host_pkg::CYC_CMD);
          pins_next.ale = (cur_reg.kind == nand_host_pkg::CYC_ADDR);
          pins_next.io_out = cur_reg.data;
          pins_next.io_oe = (cur_reg.kind != nand_host_pkg::CYC_READ);
          if (cur_reg.kind == nand_host_pkg::CYC_READ) begin
            pins_next.read_out_strobe_n = 1'b0;
          end else begin
            pins_next.write_n = 1'b0;
          end
          cnt_next = 8'(nand_host_pkg::HALF_STROBE_CYC);
          phase_next = P_LOW;
        end
      end
      P_LOW: begin
        if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          // sample just before the rising edge: data is long settled
          if (cur_reg.kind == nand_host_pkg::CYC_READ) begin
            byte_next = io_in;
          end
          pins_next.read_out_strobe_n = 1'b1;
          pins_next.write_n = 1'b1;
          cnt_next = 8'(nand_host_pkg::HALF_STROBE_CYC);
          phase_next = P_HIGH;
        end
      end
      P_HIGH: begin
        if (cnt_reg != 8'h00) begin
          cnt_next = cnt_reg - 8'h01;
        end else begin
          pins_next.cle = 1'b0;
          pins_next.ale = 1'b0;
          pins_next.io_oe = 1'b0;
          last_rd_next = (cur_reg.kind == nand_host_pkg::CYC_READ);
          done_next = 1'b1;
          phase_next = P_IDLE;
        end
      end
      default: begin
        phase_next = P_IDLE;
      end
    endcase
  end

  // registers only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      phase_reg <= P_IDLE;
      cnt_reg <= 8'h00;
      cur_reg <= '0;
      pins_reg <= '{cle: 1'b0, ale: 1'b0, write_n: 1'b1, read_out_strobe_n: 1'b1,
                    io_out: 8'h00, io_oe: 1'b0};
      done_reg <= 1'b0;
      byte_reg <= 8'h00;
      last_rd_reg <= 1'b0;
    end else begin
      phase_reg <= phase_next;
      cnt_reg <= cnt_next;
      cur_reg <= cur_next;
      pins_reg <= pins_next;
      done_reg <= done_next;
      byte_reg <= byte_next;
      last_rd_reg <= last_rd_next;
    end
  end

  // ==========================================================
  // checks
  strobe_width_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(pins_reg.read_out_strobe_n) |-> !pins_reg.read_out_strobe_n[*3])
    else $error("read strobe low shorter than half period");
  no_drive_on_read_a: assert property (@(posedge ref_clk) disable iff (reset)
    !pins_reg.read_out_strobe_n |-> !pins_reg.io_oe)
    else $error("host drives io while strobing a read");
endmodule : nand_cycle_engine

/* File: rtl/nand_host_pkg.sv */
// Purpose: shared constants and carriers for the nand page-read host
// Assumes: 200 MHz ref_clk, byte-wide multiplexed flash port
// Notes: pin timing is held here as times and derived cycle counts; busy settle only as cycles
package nand_host_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_PERIOD_NS = 5;
  localparam int ARRAY_TO_CACHE_TIME_NS = 25000;  // longest page transfer
  localparam int ARRAY_TO_CACHE_CYC = ARRAY_TO_CACHE_TIME_NS / CLK_PERIOD_NS;
  localparam int STROBE_CYCLE_NS = 25;  // least read-strobe period
  localparam int HALF_STROBE_CYC = (STROBE_CYCLE_NS / 2 + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int WRITE_TO_STROBE_NS = 80;  // write-high to read-strobe low
  localparam int WRITE_TO_STROBE_CYC = (WRITE_TO_STROBE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int STROBE_TO_WRITE_NS = 100;  // read-strobe high to write low
  localparam int STROBE_TO_WRITE_CYC = (STROBE_TO_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int BUSY_SETTLE_CYC = 4;  // the busy timer must pass this before the ready pin is trusted
  // ==========================================================
  // command codes
  localparam logic [7:0] CMD_READ_SETUP = 8'h00;
  localparam logic [7:0] CMD_READ_CONFIRM = 8'h30;
  localparam logic [7:0] CMD_IDENTITY = 8'h90;
  localparam logic [7:0] CMD_STATUS = 8'h70;
  localparam logic [7:0] CMD_COL_CHANGE = 8'h05;
  localparam logic [7:0] CMD_COL_CONFIRM = 8'hE0;
  localparam logic [7:0] ID_ADDR = 8'h00;
  // ==========================================================
  // geometry and status bits
  localparam int ID_BYTES = 5;
  localparam int STATUS_READY_BIT = 6;
  localparam int STATUS_FAIL_BIT = 0;
  // ==========================================================
  // software register map (word index on the plain port)
  localparam logic [3:0] REG_CTRL = 4'h0;    // write: op code starts it
  localparam logic [3:0] REG_ADDR = 4'h1;    // column[11:0] / row[27:12]
  localparam logic [3:0] REG_STATUS = 4'h2;  // busy, ready pin, ready bit of last byte, timeout
  localparam logic [3:0] REG_DATA = 4'h3;    // last byte taken from the flash
  localparam logic [3:0] REG_ID_LO = 4'h4;   // identity bytes 1..4
  localparam logic [3:0] REG_ID_HI = 4'h5;   // identity byte 5
  localparam logic [3:0] REG_COUNT = 4'h6;   // bytes to strobe per read, stream or column op
  localparam logic [2:0] OP_READ = 3'h1;
  localparam logic [2:0] OP_IDENT = 3'h2;
  localparam logic [2:0] OP_STATUS = 3'h3;
  localparam logic [2:0] OP_COLUMN = 3'h4;
  localparam logic [2:0] OP_STREAM = 3'h5;
  localparam logic [2:0] OP_READ_NOSETUP = 3'h6;
  // ==========================================================
  // one bus cycle on the flash port
  typedef enum logic [1:0] {
    CYC_CMD = 2'h0,
    CYC_ADDR = 2'h1,
    CYC_READ = 2'h2
  } cyc_kind_t;
  typedef struct packed {
    cyc_kind_t kind;
    logic [7:0] data;
  } cyc_req_t;
  typedef struct packed {
    logic cle;
    logic ale;
    logic write_n;
    logic read_out_strobe_n;
    logic [7:0] io_out;
    logic io_oe;
  } pins_t;
endpackage : nand_host_pkg

/* File: rtl/nand_page_host.sv */
// Purpose: host controller for nand page read, identity query, status
// Assumes: software port with read data one cycle after read strobe
// Notes: strobes out REG_COUNT bytes per read/stream op into REG_DATA
//
// Strobed register access and the register addresses were chosen for this implementation.
`timescale 1ns/10ps
module nand_page_host #(
  parameter int TRANSFER_CYC = nand_host_pkg::ARRAY_TO_CACHE_CYC
) (
  // clock and reset
  input wire logic ref_clk,
  input wire logic reset,
  // software port
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_write,
  input wire logic sw_read,
  output logic [31:0] sw_rdata,
  // flash pins
  output logic cle,
  output logic ale,
  output logic write_n,
  output logic read_out_strobe_n,
  output logic [7:0] io_out,
  output logic io_oe,
  input wire logic [7:0] io_in,
  input wire logic ready_busy_n
);
  // ==========================================================
  // sequencer states
  typedef enum logic [5:0] {
    S_IDLE = 6'b000001,
    S_ISSUE = 6'b000010,
    S_WAIT = 6'b000100,
    S_BUSY = 6'b001000,
    S_NEXT = 6'b010000,
    S_FAIL = 6'b100000
  } seq_t;
  seq_t st_reg, st_next;
  logic [3:0] step_reg, step_next;      // index into the op's cycle list
  logic [2:0] op_reg, op_next;          // running op
  logic [27:0] addr_reg, addr_next;     // column and row
  logic [11:0] count_reg, count_next;   // bytes to strobe per read, stream or column op
  logic [11:0] left_reg, left_next;     // bytes still to strobe
  logic [7:0] data_reg, data_next;      // last byte in
  logic [39:0] id_reg, id_next;         // five identity bytes, first low
  logic timeout_reg, timeout_next;      // transfer ran past its limit
  logic [$clog2(TRANSFER_CYC+2)-1:0] tmr_reg, tmr_next;
  logic [31:0] rdata_reg, rdata_next;
  logic eng_valid;
  nand_host_pkg::cyc_req_t eng_req;
  logic eng_done;
  logic [7:0] eng_byte;
  nand_host_pkg::pins_t eng_pins;
  logic busy;

  assign busy = (st_reg != S_IDLE);
  assign eng_valid = (st_reg == S_ISSUE);
  assign cle = eng_pins.cle;
  assign ale = eng_pins.ale;
  assign write_n = eng_pins.write_n;
  assign read_out_strobe_n = eng_pins.read_out_strobe_n;
  assign io_out = eng_pins.io_out;
  assign io_oe = eng_pins.io_oe;
  assign sw_rdata = rdata_reg;

  // ==========================================================
  // cycle list: step picks the next pin cycle for the running op
  // returns kind/data; steps past the list give a read cycle
  always_comb begin
    eng_req = '{kind: nand_host_pkg::CYC_READ, data: 8'h00};
    case (op_reg)
      nand_host_pkg::OP_READ, nand_host_pkg::OP_READ_NOSETUP: begin
        case (step_reg)
          4'h0: eng_req = '{nand_host_pkg::CYC_CMD, nand_host_pkg::CMD_READ_SETUP};
          4'h1: eng_req = '{nand_host_pkg::CYC_ADDR, addr_reg[7:0]};
          4'h2: eng_req = '{nand_host_pkg::CYC_ADDR, {4'h0, addr_reg[11:8]}};
          4'h3: eng_req = '{nand_host_pkg::CYC_ADDR, addr_reg[19:12]};
          4'h4: eng_req = '{nand_host_pkg::CYC_ADDR, addr_reg[27:20]};
          4'h5: eng_req = '{nand_host_pkg::CYC_CMD, nand_host_pkg::CMD_READ_CONFIRM};
          default: eng_req = '{nand_host_pkg::CYC_READ, 8'h00};
        endcase
      end
      nand_host_pkg::OP_IDENT: begin
        case (step_reg)
          4'h0: eng_req = '{nand_host_pkg::CYC_CMD, nand_host_pkg::CMD_IDENTITY};
          4'h1: eng_req = '{nand_host_pkg::CYC_ADDR, nand_host_pkg::ID_ADDR};
          default: eng_req = '{nand_host_pkg::CYC_READ, 8'h00};
        endcase
      end
      nand_host_pkg::OP_STATUS: begin
        if (step_reg == 4'h0) begin
          eng_req = '{nand_host_pkg::CYC_CMD, nand_host_pkg::CMD_STATUS};
        end
      end
      nand_host_pkg::OP_COLUMN: begin
        case (step_reg)
          4'h0: eng_req = '{nand_host_pkg::CYC_CMD, nand_host_pkg::CMD_COL_CHANGE};
          4'h1: eng_req = '{nand_host_pkg::CYC_ADDR, addr_reg[7:0]};
          4'h2: eng_req = '{nand_host_pkg::CYC_ADDR, {4'h0, addr_reg[11:8]}};
          4'h3: eng_req = '{nand_host_pkg::CYC_CMD, nand_host_pkg::CMD_COL_CONFIRM};
          default: eng_req = '{nand_host_pkg::CYC_READ, 8'h00};
        endcase
      end
      default: eng_req = '{nand_host_pkg::CYC_READ, 8'h00};
    endcase
  end

  // ==========================================================
  // sequencer and register file next values
  always_comb begin
    st_next = st_reg;
    step_next = step_reg;
    op_next = op_reg;
    addr_next = addr_reg;
    count_next = count_reg;
    left_next = left_reg;
    data_next = data_reg;
    id_next = id_reg;
    timeout_next = timeout_reg;
    tmr_next = tmr_reg;
    rdata_next = 32'h0000_0000;
    // software writes are taken only while idle so no op sees a torn address
    if (sw_write && !busy) begin
      case (sw_addr)
        nand_host_pkg::REG_ADDR: addr_next = sw_wdata[27:0];
        nand_host_pkg::REG_COUNT: count_next = sw_wdata[11:0];
        nand_host_pkg::REG_CTRL: begin
          op_next = sw_wdata[2:0];
          timeout_next = 1'b0;
          // skipping 00h relies on read mode after power-up
          step_next = (sw_wdata[2:0] == nand_host_pkg::OP_READ_NOSETUP) ? 4'h1 : 4'h0;
          left_next = (sw_wdata[2:0] == nand_host_pkg::OP_IDENT) ?
                      12'(nand_host_pkg::ID_BYTES) :
                      (sw_wdata[2:0] == nand_host_pkg::OP_STATUS) ? 12'h001 : count_reg;
          if (sw_wdata[2:0] != 3'h0 && sw_wdata[2:0] != 3'h7) begin
            st_next = (sw_wdata[2:0] == nand_host_pkg::OP_STREAM) ? S_NEXT : S_ISSUE;
          end
        end
        default: begin
        end
      endcase
    end
    if (sw_read) begin
      case (sw_addr)
        nand_host_pkg::REG_ADDR: rdata_next = {4'h0, addr_reg};
        nand_host_pkg::REG_COUNT: rdata_next = {20'h0_0000, count_reg};
        nand_host_pkg::REG_STATUS: rdata_next = {28'h000_0000, timeout_reg,
                                                 data_reg[nand_host_pkg::STATUS_READY_BIT],
                                                 ready_busy_n, busy};
        nand_host_pkg::REG_DATA: rdata_next = {24'h00_0000, data_reg};
        nand_host_pkg::REG_ID_LO: rdata_next = id_reg[31:0];
        nand_host_pkg::REG_ID_HI: rdata_next = {24'h00_0000, id_reg[39:32]};
        default: rdata_next = 32'h0000_0000;
      endcase
    end
    case (st_reg)
      S_IDLE: begin
      end
      S_ISSUE: st_next = S_WAIT;
      S_WAIT: begin
        if (eng_done) begin
          if (eng_req.kind == nand_host_pkg::CYC_READ) begin
            data_next = eng_byte;
            if (op_reg == nand_host_pkg::OP_IDENT) begin
              id_next = {eng_byte, id_reg[39:8]};  // first byte ends lowest
            end
            left_next = left_reg - 12'h001;  // device steps its column
          end else begin
            step_next = step_reg + 4'h1;
          end
          if ((op_reg == nand_host_pkg::OP_READ || op_reg == nand_host_pkg::OP_READ_NOSETUP)
              && step_reg == 4'h5) begin
            tmr_next = '0;
            st_next = S_BUSY;
          end else begin
            st_next = S_NEXT;
          end
        end
      end
      S_BUSY: begin
        // settle: give the device a few cycles to pull busy low
        tmr_next = tmr_reg + 1'b1;
        if (tmr_reg > ($bits(tmr_reg))'(nand_host_pkg::BUSY_SETTLE_CYC) && ready_busy_n) begin
          st_next = S_NEXT;
        end else if (tmr_reg == ($bits(tmr_reg))'(TRANSFER_CYC)) begin
          timeout_next = 1'b1;
          st_next = S_FAIL;
        end
      end
      S_NEXT: begin
        if (eng_req.kind == nand_host_pkg::CYC_READ && left_reg == 12'h000) begin
          st_next = S_IDLE;
        end else if (op_reg == nand_host_pkg::OP_STREAM && !ready_busy_n) begin
          st_next = S_NEXT;
        end else begin
          st_next = S_ISSUE;
        end
      end
      S_FAIL: st_next = S_IDLE;
      default: st_next = S_IDLE;
    endcase
  end

  // registers only
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      st_reg <= S_IDLE;
      step_reg <= 4'h0;
      op_reg <= 3'h0;
      addr_reg <= 28'h000_0000;
      count_reg <= 12'h001;
      left_reg <= 12'h000;
      data_reg <= 8'h00;
      id_reg <= 40'h00_0000_0000;
      timeout_reg <= 1'b0;
      tmr_reg <= '0;
      rdata_reg <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
      step_reg <= step_next;
      op_reg <= op_next;
      addr_reg <= addr_next;
      count_reg <= count_next;
      left_reg <= left_next;
      data_reg <= data_next;
      id_reg <= id_next;
      timeout_reg <= timeout_next;
      tmr_reg <= tmr_next;
      rdata_reg <= rdata_next;
    end
  end

  nand_cycle_engine u_engine (
    .ref_clk(ref_clk),
    .reset(reset),
    .req_valid(eng_valid),
    .req(eng_req),
    .done(eng_done),
    .rd_byte(eng_byte),
    .io_in(io_in),
    .pins(eng_pins)
  );

  // ==========================================================
  // checks
  sequence confirm_sent_s;
    st_reg == S_WAIT && eng_done && step_reg == 4'h5 &&
    (op_reg == nand_host_pkg::OP_READ || op_reg == nand_host_pkg::OP_READ_NOSETUP);
  endsequence
  wait_ready_a: assert property (@(posedge ref_clk) disable iff (reset)
    confirm_sent_s |=> st_reg == S_BUSY)
    else $error("read strobes not held off after confirm");
  busy_exit_a: assert property (@(posedge ref_clk) disable iff (reset)
    (st_reg == S_BUSY && $past(st_reg) == S_BUSY && st_next == S_NEXT) |-> ready_busy_n)
    else $error("left busy wait without ready");
  id_count_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sw_write && !busy && sw_addr == nand_host_pkg::REG_CTRL &&
     sw_wdata[2:0] == nand_host_pkg::OP_IDENT) |=> left_reg == 12'h005)
    else $error("identity op not set for five bytes");
  nosetup_skip_a: assert property (@(posedge ref_clk) disable iff (reset)
    (sw_write && !busy && sw_addr == nand_host_pkg::REG_CTRL &&
     sw_wdata[2:0] == nand_host_pkg::OP_READ_NOSETUP) |=> step_reg == 4'h1)
    else $error("setup command not skipped");
  col_order_a: assert property (@(posedge ref_clk) disable iff (reset)
    (eng_valid && op_reg == nand_host_pkg::OP_READ && step_reg == 4'h2) |->
     eng_req.data == {4'h0, addr_reg[11:8]})
    else $error("second address cycle not column high");
  io_hold_a: assert property (@(posedge ref_clk) disable iff (reset)
    $fell(write_n) |-> io_oe ##1 io_oe)
    else $error("io not driven across write pulse");
endmodule : nand_page_host

/* File: testbench/nand_device_model.sv */
// Purpose: behavioural flash device facing the page-read host
// Assumes: commands and addresses latch on write_n rising edge
// Notes: viol counts host misuse; the bench expects it to stay zero
`timescale 1ns/10ps
module nand_device_model #(
  parameter int BUSY_CYC = 150,
  parameter logic [39:0] ID_STR = 40'h00_0000_0000
) (
  // clock, only to time the busy interval
  input wire logic ref_clk,
  // flash pins from the host
  input wire logic cle,
  input wire logic ale,
  input wire logic write_n,
  input wire logic read_out_strobe_n,
  input wire logic [7:0] io_out,
  input wire logic io_oe,
  // flash pins to the host
  output logic [7:0] io_in,
  output logic ready_busy_n,
  // misuse count
  output int viol
);
  // ==========================================================
  // state
  logic [7:0] adr [4]; // latched address cycles
  logic [7:0] dout; // byte on the bus
  logic [11:0] col; // output column
  logic [15:0] row; // cached page
  int acnt; // address cycles since last command
  int idx; // identity byte index
  int mode; // 0 page, 1 identity, 2 status
  logic busy; // page transfer running
  realtime last_fall; // previous strobe fall
  event start_xfer;
  initial begin
    viol = 0;
    busy = 1'b0;
    mode = 0;
    acnt = 0;
    idx = 0;
    dout = 8'h00;
    col = 12'h000;
    row = 16'h0000;
    last_fall = -100.0;
  end
  assign ready_busy_n = ~busy;
  // released bus shows the inverse, so a stale sample cannot pass
  assign io_in = io_oe ? io_out : (read_out_strobe_n ? ~dout : dout);
  // ==========================================================
  // command and address latch
  always @(posedge write_n) begin
    if (cle) begin
      case (io_out)
        8'h30: begin
          col = {adr[1][3:0], adr[0]};
          row = {adr[3], adr[2]};
          mode = 0;
          -> start_xfer;
        end
        8'h90: begin
          mode = 1;
          idx = 0;
        end
        8'h70: mode = 2;
        8'hE0: begin
          col = {adr[1][3:0], adr[0]};
          mode = 0;
        end
        8'h00, 8'h05: mode = 0;
        default: viol++;
      endcase
      acnt = 0;
    end else if (ale) begin
      if (acnt > 3) viol++;
      else adr[acnt] = io_out;
      acnt++;
    end
  end
  // ==========================================================
  // one byte per strobe fall
  always @(negedge read_out_strobe_n) begin
    if (busy && mode != 2) viol++;
    if ($realtime - last_fall < 25.0) viol++;
    last_fall = $realtime;
    case (mode)
      1: begin
        dout = (idx < 5) ? ID_STR[8*idx +: 8] : 8'h00;
        idx++;
      end
      2: dout = {1'b0, ~busy, 6'h00};
      default: begin
        dout = col[7:0] + row[7:0];
        if (col < 12'd2111) col++;
      end
    endcase
  end
  // busy interval, kept under the longest transfer time
  always @(start_xfer) begin
    busy = 1'b1;
    repeat (BUSY_CYC) @(posedge ref_clk);
    busy = 1'b0;
  end
endmodule : nand_device_model

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the nand page-read host
// Assumes: software port, read data one cycle after read strobe
// Notes: transfer count shortened to 200 cycles
`timescale 1ns/10ps
module tb_top;
  // ==========================================================
  // signals
  logic ref_clk, reset, sw_write, sw_read;
  logic [3:0] sw_addr;
  logic [31:0] sw_wdata, sw_rdata, rd;
  logic cle, ale, write_n, read_out_strobe_n, io_oe, ready_busy_n;
  logic [7:0] io_out, io_in;
  int err_total, check_count, viol, cycles;
  localparam logic [39:0] ID_STR = 40'h44_9141_a75a; // first two bytes arbitrary
  localparam logic [15:0] ROW = 16'h0a5c;
  nand_page_host #(.TRANSFER_CYC(200)) u_nand_page_host (.ref_clk(ref_clk), .reset(reset),
    .sw_addr(sw_addr), .sw_wdata(sw_wdata), .sw_write(sw_write), .sw_read(sw_read),
    .sw_rdata(sw_rdata), .cle(cle), .ale(ale), .write_n(write_n),
    .read_out_strobe_n(read_out_strobe_n), .io_out(io_out), .io_oe(io_oe), .io_in(io_in),
    .ready_busy_n(ready_busy_n));
  nand_device_model #(.BUSY_CYC(150), .ID_STR(ID_STR)) u_nand_device_model (.ref_clk(ref_clk),
    .cle(cle), .ale(ale), .write_n(write_n), .read_out_strobe_n(read_out_strobe_n),
    .io_out(io_out), .io_oe(io_oe), .io_in(io_in), .ready_busy_n(ready_busy_n), .viol(viol));
  // ==========================================================
  // software port tasks
  task automatic sw_wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_wdata <= d;
    sw_write <= 1'b1;
    @(posedge ref_clk);
    sw_write <= 1'b0;
  endtask : sw_wr
  task automatic sw_rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    sw_addr <= a;
    sw_read <= 1'b1;
    @(posedge ref_clk);
    sw_read <= 1'b0;
    #1 d = sw_rdata;
  endtask : sw_rd
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    check_count++;
    if (got !== exp) begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk
  // start an op and poll busy with a bound
  task automatic run_op(input logic [2:0] op, input logic [31:0] cnt);
    int n;
    sw_wr(nand_host_pkg::REG_COUNT, cnt);
    sw_wr(nand_host_pkg::REG_CTRL, {29'h0, op});
    n = 0;
    rd = 32'h0000_0001;
    while (rd[0] !== 1'b0 && n < 2000) begin
      sw_rd(nand_host_pkg::REG_STATUS, rd);
      n++;
    end
    // a poll limit that runs out is a mismatch
    chk("op done", 32'h0000_0000, {31'h0000_0000, rd[0]});
  endtask : run_op
  // page byte pattern of the device model
  function automatic logic [31:0] pg(input logic [11:0] c, input logic [15:0] r);
    return {24'h00_0000, c[7:0] + r[7:0]};
  endfunction : pg
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : print_verdict
  // ==========================================================
  // clock, reset and hang guard
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  always @(posedge ref_clk) begin
    cycles++;
    if (cycles == 40000) begin
      err_total++;
      print_verdict();
    end
  end
  // ==========================================================
  // scenarios
  initial begin
    reset = 1'b1;
    sw_addr = 4'h0;
    sw_wdata = 32'h0000_0000;
    sw_write = 1'b0;
    sw_read = 1'b0;
    repeat (5) @(posedge ref_clk);
    reset <= 1'b0;
    sw_rd(nand_host_pkg::REG_COUNT, rd);
    chk("count reset", 32'h0000_0001, rd);
    // first read after power-up skips the setup command
    sw_wr(nand_host_pkg::REG_ADDR, {4'h0, ROW, 12'h123});
    run_op(nand_host_pkg::OP_READ_NOSETUP, 4);
    sw_rd(nand_host_pkg::REG_DATA, rd);
    chk("nosetup byte", pg(12'h126, ROW), rd);
    run_op(nand_host_pkg::OP_STREAM, 3);
    sw_rd(nand_host_pkg::REG_DATA, rd);
    chk("stream byte", pg(12'h129, ROW), rd);
    // column change twice within the cached page
    for (int i = 0; i < 2; i++) begin
      sw_wr(nand_host_pkg::REG_ADDR, {4'h0, ROW, (i == 0) ? 12'h7fe : 12'h010});
      run_op(nand_host_pkg::OP_COLUMN, 2);
      sw_rd(nand_host_pkg::REG_DATA, rd);
      chk("column byte", pg((i == 0) ? 12'h7ff : 12'h011, ROW), rd);
    end
    // status: ready, no failure
    run_op(nand_host_pkg::OP_STATUS, 1);
    sw_rd(nand_host_pkg::REG_DATA, rd);
    chk("status byte", 32'h0000_0040, rd);
    sw_rd(nand_host_pkg::REG_STATUS, rd);
    chk("status reg", 32'h0000_0006, rd & 32'h0000_000f);
    // full read ending on the last spare column
    sw_wr(nand_host_pkg::REG_ADDR, {4'h0, 16'h3c01, 12'h83e});
    run_op(nand_host_pkg::OP_READ, 2);
    sw_rd(nand_host_pkg::REG_DATA, rd);
    chk("last column", pg(12'h83f, 16'h3c01), rd);
    // identity string
    run_op(nand_host_pkg::OP_IDENT, 5);
    sw_rd(nand_host_pkg::REG_ID_LO, rd);
    chk("id low", ID_STR[31:0], rd);
    sw_rd(nand_host_pkg::REG_ID_HI, rd);
    chk("id high", {24'h00_0000, ID_STR[39:32]}, rd & 32'h0000_00ff);
    chk("pin misuse", 32'h0000_0000, viol);
    print_verdict();
  end
endmodule : tb_top
